// [rtl/dtcm_defines.svh]
// Purpose: Offsets, field values, reset values and timing counts of the trouble code messenger
// Assumes: 20 MHz system clock
// Notes: Definitions only
`ifndef DTCM_DEFINES_SVH
`define DTCM_DEFINES_SVH

// ==========================================================
// Timing
`define DTCM_CLK_HZ 20000000
`define DTCM_UPDATE_MS 1000
`define DTCM_TICK_CYCLES ((`DTCM_CLK_HZ / 1000) * `DTCM_UPDATE_MS)

// ==========================================================
// Register offsets (byte addresses)
`define DTCM_REG_CTRL 8'h00
`define DTCM_REG_STATUS 8'h04
`define DTCM_REG_INT_STAT 8'h08
`define DTCM_REG_INT_MASK 8'h0C
`define DTCM_CTRL_RESET 32'h0000_0001
`define DTCM_MASK_RESET 4'h0
`define DTCM_CTRL_EN_BIT 0
`define DTCM_STAT_BUSY_BIT 16

// Interrupt status bits
`define DTCM_INT_ACTIVE_SENT 0
`define DTCM_INT_PREV_SENT 1
`define DTCM_INT_NACK_SENT 2
`define DTCM_INT_CLEARED 3

// ==========================================================
// Group numbers and message fields
`define DTCM_PGN_REQUEST 18'h0_EA00
`define DTCM_PGN_ACK 18'h0_E800
`define DTCM_PGN_ACTIVE 18'h0_FECA
`define DTCM_PGN_PREV 18'h0_FECB
`define DTCM_PGN_CLEAR 18'h0_FECC
`define DTCM_PRIO_DEFAULT 3'h6
`define DTCM_NACK_CTRL 8'h01
`define DTCM_BYTE_ONES 8'hFF
`define DTCM_BYTE_ZERO 8'h00
`define DTCM_LAMP_ON 2'h1
`define DTCM_LAMP_OFF 2'h0
`define DTCM_SINGLE_LEN 8'h08
`define DTCM_LAMP_LEN 8'h02
`define DTCM_SLOTS 8

`endif

// [rtl/dtcm_messenger.sv]
// Purpose: Builds and schedules active and previously-active trouble code messages and NACK replies
// Assumes: Fault, lamp and request inputs come from logic on clk; volt_ok is a pin
// Notes: Bytes leave one at a time through a valid/ready port to the transport layer
`timescale 1ns/1ns
`include "dtcm_defines.svh"

module dtcm_messenger #(
  parameter int unsigned TICK_CYCLES = `DTCM_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic fault_upd,
  input wire logic [2:0] fault_slot,
  input wire logic fault_act,
  input wire dtcm_pkg::dtcm_fault_t fault_rec,
  input wire logic [3:0] lamp_on,
  input wire logic req_valid,
  input wire logic [17:0] req_pgn,
  input wire logic volt_ok,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_first,
  output logic tx_last,
  output dtcm_pkg::dtcm_hdr_t tx_hdr,
  output logic irq
);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] rec_byte(input dtcm_pkg::dtcm_fault_t r, input logic [1:0] k);
    logic [7:0] b;
    b = '0;
    unique case (k)
      2'd0: b = r.spn[7:0];
      2'd1: b = r.spn[15:8];
      2'd2: b = {r.spn[18:16], r.fmi};
      2'd3: b = {r.cm, r.oc};
    endcase
    return b;
  endfunction

  function automatic logic [3:0] count_ones(input logic [7:0] m);
    logic [3:0] n;
    n = '0;
    for (int i = 0; i < `DTCM_SLOTS; i++) begin
      n = n + {3'b0, m[i]};
    end
    return n;
  endfunction

  // ==========================================================
  // Pin synchroniser for the supply-good level
  logic volt_meta_q;
  logic volt_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      volt_meta_q <= 1'b0;
      volt_q <= 1'b0;
    end else begin
      volt_meta_q <= volt_ok;
      volt_q <= volt_meta_q;
    end
  end

  // ==========================================================
  // Free-running update timer; extra reports never restart it
  logic [24:0] tick_cnt_q;
  wire tick = (tick_cnt_q == 25'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 25'd1;
    end
  end

  // ==========================================================
  // Registers
  logic [31:0] ctrl_q;
  logic [3:0] int_stat_q;
  logic [3:0] int_mask_q;
  logic busy;
  logic [3:0] events;
  logic [7:0] active_q;
  logic [7:0] prev_q;

  wire sel_ctrl = (reg_addr == `DTCM_REG_CTRL);
  wire sel_status = (reg_addr == `DTCM_REG_STATUS);
  wire sel_int = (reg_addr == `DTCM_REG_INT_STAT);
  wire sel_mask = (reg_addr == `DTCM_REG_INT_MASK);
  wire enable = ctrl_q[`DTCM_CTRL_EN_BIT];
  wire int_rd_clr = reg_rd && sel_int;
  wire [31:0] status_word = {15'b0, busy, prev_q, active_q};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_q :
                       sel_status ? status_word :
                       sel_int ? {28'b0, int_stat_q} :
                       sel_mask ? {28'b0, int_mask_q} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_q <= `DTCM_CTRL_RESET;
      int_mask_q <= `DTCM_MASK_RESET;
      int_stat_q <= '0;
      reg_rdata <= '0;
    end else begin
      if (reg_wr && sel_ctrl) begin
        ctrl_q <= {31'b0, reg_wdata[`DTCM_CTRL_EN_BIT]};
      end
      if (reg_wr && sel_mask) begin
        int_mask_q <= reg_wdata[3:0];
      end
      // New events win over the read that clears
      int_stat_q <= (int_rd_clr ? 4'h0 : int_stat_q) | events;
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign irq = |(int_stat_q & int_mask_q);

  // ==========================================================
  // Fault table
  dtcm_pkg::dtcm_fault_t rec_q [`DTCM_SLOTS];
  logic [7:0] seen_q;
  logic any_q;
  logic pend_act_q;
  logic pend_prev_q;
  logic pend_nack_q;
  logic [17:0] nack_pgn_q;
  logic take_act;
  logic take_prev;
  logic take_nack;

  wire [7:0] slot_bit = 8'h01 << fault_slot;
  wire going_on = fault_upd && fault_act && !active_q[fault_slot];
  wire going_off = fault_upd && !fault_act && active_q[fault_slot];
  wire new_code = going_on && !seen_q[fault_slot];
  wire periodic = tick && (any_q || (|active_q));
  wire req_active = req_valid && (req_pgn == `DTCM_PGN_ACTIVE);
  wire req_prev = req_valid && (req_pgn == `DTCM_PGN_PREV);
  wire req_clear = req_valid && (req_pgn == `DTCM_PGN_CLEAR);
  wire clear_ok = req_clear && volt_q;
  wire req_bad = req_valid && !req_active && !req_prev && !req_clear;
  wire clear_nack = req_clear && !volt_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      active_q <= '0;
      prev_q <= '0;
      seen_q <= '0;
      any_q <= 1'b0;
    end else begin
      if (fault_upd) begin
        active_q <= fault_act ? (active_q | slot_bit) : (active_q & ~slot_bit);
      end
      // A code that falls away while clearing still lands in the table
      prev_q <= (clear_ok ? 8'h00 : prev_q) | (going_off ? slot_bit : 8'h00);
      seen_q <= (tick ? 8'h00 : seen_q) | (going_on ? slot_bit : 8'h00);
      any_q <= tick ? 1'b0 : (any_q || (|active_q));
    end
  end

  always_ff @(posedge clk) begin
    if (fault_upd && fault_act) begin
      rec_q[fault_slot] <= fault_rec;
    end
  end

  // ==========================================================
  // Pending work; a new demand wins over the take of the old one
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend_act_q <= 1'b0;
      pend_prev_q <= 1'b0;
      pend_nack_q <= 1'b0;
      nack_pgn_q <= '0;
    end else begin
      pend_act_q <= (pend_act_q && !take_act) ||
                    (enable && (periodic || new_code)) || req_active;
      pend_prev_q <= (pend_prev_q && !take_prev) || req_prev;
      pend_nack_q <= (pend_nack_q && !take_nack) || req_bad || clear_nack;
      if (req_bad || clear_nack) begin
        nack_pgn_q <= req_pgn;
      end
    end
  end

  // ==========================================================
  // Byte generator and output stage
  dtcm_pkg::dtcm_state_t state_q;
  dtcm_pkg::dtcm_kind_t kind_q;
  logic [7:0] snap_q;
  logic [2:0] slot_q;
  logic [2:0] k_q;

  wire out_free = !tx_valid || tx_ready;
  wire [7:0] lamp_byte = {lamp_on[3] ? `DTCM_LAMP_ON : `DTCM_LAMP_OFF,
                          lamp_on[2] ? `DTCM_LAMP_ON : `DTCM_LAMP_OFF,
                          lamp_on[1] ? `DTCM_LAMP_ON : `DTCM_LAMP_OFF,
                          lamp_on[0] ? `DTCM_LAMP_ON : `DTCM_LAMP_OFF};
  wire idle = (state_q == dtcm_pkg::DTCM_S_IDLE);
  // Header must hold until the last byte of the message before has gone
  wire start_ok = idle && out_free;
  assign take_nack = start_ok && pend_nack_q;
  assign take_prev = start_ok && !pend_nack_q && pend_prev_q;
  assign take_act = start_ok && !pend_nack_q && !pend_prev_q && pend_act_q;
  assign busy = !idle;

  // Contents fixed at start: every currently active code, or every previously active code for a previous report
  wire [7:0] start_mask = take_prev ? prev_q : active_q;
  wire [3:0] start_cnt = count_ones(start_mask);
  wire [7:0] start_len = (start_cnt == 4'd0) ? `DTCM_SINGLE_LEN :
                         `DTCM_LAMP_LEN + {2'b0, start_cnt, 2'b0};
  wire rec_here = snap_q[slot_q];
  wire [7:0] above = snap_q >> slot_q;
  wire rec_final = (above[7:1] == 7'h00);
  wire [7:0] rec_out = rec_byte(rec_q[slot_q], k_q[1:0]);
  wire [7:0] empty_out = (k_q < 3'd4) ? `DTCM_BYTE_ZERO : `DTCM_BYTE_ONES;
  wire [7:0] nack_out = (k_q == 3'd0) ? `DTCM_NACK_CTRL :
                        (k_q == 3'd5) ? nack_pgn_q[7:0] :
                        (k_q == 3'd6) ? nack_pgn_q[15:8] :
                        (k_q == 3'd7) ? {6'b0, nack_pgn_q[17:16]} : `DTCM_BYTE_ONES;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= dtcm_pkg::DTCM_S_IDLE;
      kind_q <= dtcm_pkg::DTCM_KIND_ACTIVE;
      snap_q <= '0;
      slot_q <= '0;
      k_q <= '0;
      tx_hdr <= '0;
    end else begin
      unique case (state_q)
        dtcm_pkg::DTCM_S_IDLE: begin
          k_q <= '0;
          slot_q <= '0;
          snap_q <= start_mask;
          if (take_nack) begin
            kind_q <= dtcm_pkg::DTCM_KIND_NACK;
            state_q <= dtcm_pkg::DTCM_S_NACK;
            tx_hdr <= {`DTCM_PRIO_DEFAULT, `DTCM_PGN_ACK, 1'b0, `DTCM_SINGLE_LEN};
          end else if (take_prev || take_act) begin
            kind_q <= take_prev ? dtcm_pkg::DTCM_KIND_PREV : dtcm_pkg::DTCM_KIND_ACTIVE;
            state_q <= dtcm_pkg::DTCM_S_LAMP;
            tx_hdr <= {`DTCM_PRIO_DEFAULT, take_prev ? `DTCM_PGN_PREV : `DTCM_PGN_ACTIVE,
                       start_cnt > 4'd1, start_len};
          end
        end
        dtcm_pkg::DTCM_S_LAMP: begin
          if (out_free) begin
            state_q <= dtcm_pkg::DTCM_S_RSV;
          end
        end
        dtcm_pkg::DTCM_S_RSV: begin
          if (out_free) begin
            state_q <= (snap_q == 8'h00) ? dtcm_pkg::DTCM_S_EMPTY : dtcm_pkg::DTCM_S_REC;
          end
        end
        dtcm_pkg::DTCM_S_REC: begin
          if (!rec_here) begin
            slot_q <= slot_q + 3'd1;
          end else if (out_free) begin
            k_q <= (k_q == 3'd3) ? 3'd0 : k_q + 3'd1;
            if (k_q == 3'd3) begin
              slot_q <= slot_q + 3'd1;
              if (rec_final) begin
                state_q <= dtcm_pkg::DTCM_S_IDLE;
              end
            end
          end
        end
        dtcm_pkg::DTCM_S_EMPTY: begin
          if (out_free) begin
            k_q <= k_q + 3'd1;
            if (k_q == 3'd5) begin
              state_q <= dtcm_pkg::DTCM_S_IDLE;
            end
          end
        end
        dtcm_pkg::DTCM_S_NACK: begin
          if (out_free) begin
            k_q <= k_q + 3'd1;
            if (k_q == 3'd7) begin
              state_q <= dtcm_pkg::DTCM_S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // What the generator offers this cycle
  logic gen_valid;
  logic [7:0] gen_data;
  logic gen_first;
  logic gen_last;

  always_comb begin
    gen_valid = 1'b0;
    gen_data = `DTCM_BYTE_ZERO;
    gen_first = 1'b0;
    gen_last = 1'b0;
    unique case (state_q)
      dtcm_pkg::DTCM_S_IDLE: begin
        gen_valid = 1'b0;
      end
      dtcm_pkg::DTCM_S_LAMP: begin
        gen_valid = 1'b1;
        gen_data = lamp_byte;
        gen_first = 1'b1;
      end
      dtcm_pkg::DTCM_S_RSV: begin
        gen_valid = 1'b1;
        gen_data = `DTCM_BYTE_ONES;
      end
      dtcm_pkg::DTCM_S_REC: begin
        gen_valid = rec_here;
        gen_data = rec_out;
        gen_last = rec_final && (k_q == 3'd3);
      end
      dtcm_pkg::DTCM_S_EMPTY: begin
        gen_valid = 1'b1;
        gen_data = empty_out;
        gen_last = (k_q == 3'd5);
      end
      dtcm_pkg::DTCM_S_NACK: begin
        gen_valid = 1'b1;
        gen_data = nack_out;
        gen_first = (k_q == 3'd0);
        gen_last = (k_q == 3'd7);
      end
    endcase
  end

  wire load = gen_valid && out_free;
  wire done = load && gen_last;
  assign events = {clear_ok,
                   done && (kind_q == dtcm_pkg::DTCM_KIND_NACK),
                   done && (kind_q == dtcm_pkg::DTCM_KIND_PREV),
                   done && (kind_q == dtcm_pkg::DTCM_KIND_ACTIVE)};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_valid <= 1'b0;
      tx_data <= '0;
      tx_first <= 1'b0;
      tx_last <= 1'b0;
    end else if (out_free) begin
      tx_valid <= gen_valid;
      if (gen_valid) begin
        tx_data <= gen_data;
        tx_first <= gen_first;
        tx_last <= gen_last;
      end
    end
  end

endmodule

// [rtl/dtcm_pkg.sv]
// Purpose: Types shared by the trouble code messenger and its users
// Assumes: Constants live in dtcm_defines.svh
// Notes: Types only
package dtcm_pkg;

  // ==========================================================
  // One stored trouble code
  typedef struct packed {
    logic cm;
    logic [6:0] oc;
    logic [4:0] fmi;
    logic [18:0] spn;
  } dtcm_fault_t;

  // Header handed to the frame layer with the first byte
  typedef struct packed {
    logic [2:0] prio;
    logic [17:0] pgn;
    logic multi;
    logic [7:0] len;
  } dtcm_hdr_t;

  typedef enum logic [1:0] {
    DTCM_KIND_ACTIVE,
    DTCM_KIND_PREV,
    DTCM_KIND_NACK
  } dtcm_kind_t;

  typedef enum logic [2:0] {
    DTCM_S_IDLE,
    DTCM_S_LAMP,
    DTCM_S_RSV,
    DTCM_S_REC,
    DTCM_S_EMPTY,
    DTCM_S_NACK
  } dtcm_state_t;

endpackage

// [verification/dtcm_checker.sv]
// Purpose: Port checks of the trouble code messenger
// Assumes: Bound to dtcm_messenger, one clock domain
// Notes: A byte counter tracks the position inside a message
`timescale 1ns/1ns
`include "dtcm_defines.svh"

module dtcm_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] lamp_on,
  input wire logic req_valid,
  input wire logic [17:0] req_pgn,
  input wire logic volt_ok,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_first,
  input wire logic tx_last,
  input wire dtcm_pkg::dtcm_hdr_t tx_hdr
);
  // ==========================================================
  // Byte position
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] lamp_b;
  assign cnt_d = !(tx_valid && tx_ready) ? cnt_q : (tx_last ? 8'h00 : cnt_q + 8'h01);
  assign lamp_b = {1'b0, lamp_on[3], 1'b0, lamp_on[2], 1'b0, lamp_on[1], 1'b0, lamp_on[0]};
  always_ff @(posedge clk) begin
    cnt_q <= !nrst ? 8'h00 : cnt_d;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Checks
  byte_hold_a: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_hdr))
    else $error("byte changed before taken");
  prio_six_a: assert property (
    tx_valid |-> tx_hdr.prio == `DTCM_PRIO_DEFAULT) else $error("priority not 6");
  rsv_ones_a: assert property (
    tx_valid && tx_ready && tx_first |=> tx_valid && tx_data == 8'hFF)
    else $error("second byte not all ones");
  multi_flag_a: assert property (
    tx_valid && tx_first |-> tx_hdr.multi == (tx_hdr.len > 8'h08))
    else $error("multi flag wrong");
  msg_len_a: assert property (
    tx_valid && tx_last |-> cnt_q + 8'h01 == tx_hdr.len) else $error("byte count off");
  nack_form_a: assert property (
    tx_valid && tx_first && tx_hdr.pgn == `DTCM_PGN_ACK |-> tx_data == 8'h01 &&
    tx_hdr.len == 8'h08) else $error("nack form wrong");
  lamp_byte_a: assert property (
    tx_valid && tx_first && tx_hdr.pgn != `DTCM_PGN_ACK |-> tx_data == lamp_b)
    else $error("lamp byte wrong");
  prev_ask_a: assert property (
    req_valid && req_pgn == `DTCM_PGN_PREV |-> ##[3:1000]
    (tx_valid && tx_first && tx_hdr.pgn == `DTCM_PGN_PREV)) else $error("no previous report");
  low_volt_a: assert property (
    req_valid && req_pgn == `DTCM_PGN_CLEAR &&
    !(volt_ok | $past(volt_ok) | $past(volt_ok, 2) | $past(volt_ok, 3)) |-> ##[3:1000]
    (tx_valid && tx_first && tx_hdr.pgn == `DTCM_PGN_ACK)) else $error("clear not refused");
endmodule

// [verification/dtcm_partner.sv]
// Purpose: Transport layer model that takes message bytes
// Assumes: A byte is taken on tx_valid and tx_ready
// Notes: Slow mode stalls at random to stretch messages
`timescale 1ns/1ns

module dtcm_partner (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_first,
  input wire logic tx_last,
  input wire dtcm_pkg::dtcm_hdr_t tx_hdr,
  output logic got_done,
  output int got_n,
  output logic [7:0] got_b [34],
  output dtcm_pkg::dtcm_hdr_t got_hdr
);
  integer seed = 32'h0ffb_07f7;
  int n = 0;
  // Long payloads arrive whole as one multi-packet message
  always @(posedge clk) begin
    got_done <= 1'b0;
    tx_ready <= nrst && (!slow || ($random(seed) & 3) == 0);
    if (tx_valid && tx_ready) begin
      if (tx_first) n = 0;
      if (tx_first) got_hdr <= tx_hdr;
      if (n < 34) got_b[n] <= tx_data;
      n = n + 1;
      if (tx_last) got_n <= n;
      if (tx_last) got_done <= 1'b1;
    end
  end
endmodule

// [verification/tb.sv]
// Purpose: Self-checking bench of the trouble code messenger
// Assumes: Update interval shortened to TK cycles
// Notes: Expected messages are queued in emission order
`timescale 1ns/1ns
`include "dtcm_defines.svh"

module tb;
  localparam int TK = 200;
  typedef struct {
    dtcm_pkg::dtcm_hdr_t h;
    logic [7:0] b [34];
    logic tk;
  } dtcm_exp_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic fault_upd = 1'b0;
  logic [2:0] fault_slot = 3'h0;
  logic fault_act = 1'b0;
  dtcm_pkg::dtcm_fault_t fault_rec = '0;
  logic [3:0] lamp_on = 4'h2;
  logic req_valid = 1'b0;
  logic [17:0] req_pgn = 18'h0_0000;
  logic volt_ok = 1'b0;
  logic slow = 1'b0;
  logic tx_valid, tx_ready, tx_first, tx_last, irq, got_done;
  logic [7:0] tx_data;
  logic [7:0] got_b [34];
  dtcm_pkg::dtcm_hdr_t tx_hdr, got_hdr;
  dtcm_pkg::dtcm_fault_t rec [8];
  int got_n, cyc = 0, st = 0, n_errors = 0, check_count = 0;
  integer seed = 32'h0ffb_07f7;
  logic [7:0] act_m = 8'h00, prev_m = 8'h00;
  dtcm_exp_t mq [$];
  logic [31:0] rq [$];
  logic rd_d = 1'b0;
  logic ofr_d = 1'b0;

  always #25 clk = ~clk;

  dtcm_messenger #(.TICK_CYCLES(TK)) DUT (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .fault_upd, .fault_slot, .fault_act, .fault_rec, .lamp_on,
    .req_valid, .req_pgn, .volt_ok, .tx_valid, .tx_ready, .tx_data, .tx_first, .tx_last,
    .tx_hdr, .irq);
  dtcm_partner u_far (.clk, .nrst, .slow, .tx_valid, .tx_ready, .tx_data, .tx_first,
    .tx_last, .tx_hdr, .got_done, .got_n, .got_b, .got_hdr);

  // ==========================================================
  // Compare and closing
  task automatic fail(input string m);
    n_errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) fail(m);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp_reg();
    if (rq.size() == 0) fail("stray read data");
    else chk(reg_rdata === rq.pop_front(), "register read");
  endtask
  task automatic cmp_irq(input logic x);
    repeat (2) @(posedge clk);
    chk(irq === x, "interrupt level");
  endtask
  task automatic cmp_msg();
    dtcm_exp_t e;
    if (mq.size() == 0) begin
      fail("unexpected message");
      return;
    end
    e = mq.pop_front();
    chk(got_hdr === e.h, "header");
    chk(8'(got_n) === e.h.len, "length");
    for (int i = 0; i < got_n && i < 34; i++) chk(got_b[i] === e.b[i], "byte");
    if (e.tk) chk(st < 8, "periodic report late");
  endtask

  always @(posedge clk) begin
    cyc <= nrst ? cyc + 1 : 0;
    rd_d <= reg_rd;
    ofr_d <= tx_valid && tx_first;
    // Offer time, so partner stalls do not count against the design
    if (tx_valid && tx_first && !ofr_d) st <= cyc % TK;
    if (rd_d) cmp_reg();
    if (got_done) cmp_msg();
  end

  // ==========================================================
  // Expected messages from the fault model
  task automatic push(input logic [17:0] pgn, input logic tk, input logic nk);
    dtcm_exp_t e;
    logic [7:0] m;
    int n;
    m = pgn == `DTCM_PGN_PREV ? prev_m : act_m;
    n = 0;
    e.tk = tk;
    e.b[0] = {1'b0, lamp_on[3], 1'b0, lamp_on[2], 1'b0, lamp_on[1], 1'b0, lamp_on[0]};
    e.b[1] = 8'hFF;
    for (int s = 0; s < 8; s++) begin
      if (m[s]) begin
        {e.b[4*n+5], e.b[4*n+4], e.b[4*n+3], e.b[4*n+2]} = {rec[s].cm, rec[s].oc,
          rec[s].spn[18:16], rec[s].fmi, rec[s].spn[15:0]};
        n++;
      end
    end
    if (n == 0) {e.b[2], e.b[3], e.b[4], e.b[5], e.b[6], e.b[7]} = 48'h0000_0000_FFFF;
    e.h = '{`DTCM_PRIO_DEFAULT, pgn, n > 1, n == 0 ? 8'h08 : 8'(2 + 4 * n)};
    if (nk) begin
      e.h = '{`DTCM_PRIO_DEFAULT, `DTCM_PGN_ACK, 1'b0, 8'h08};
      {e.b[0], e.b[1], e.b[2], e.b[3], e.b[4], e.b[5], e.b[6], e.b[7]} =
        {8'h01, 32'hFFFF_FFFF, pgn[7:0], pgn[15:8], 6'h00, pgn[17:16]};
    end
    mq.push_back(e);
  endtask

  // ==========================================================
  // Drivers
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) rq.push_back(d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  task automatic flt(input int s, input logic a);
    if (a) rec[s] = $random(seed);
    @(posedge clk);
    fault_upd <= 1'b1;
    fault_slot <= 3'(s);
    fault_act <= a;
    fault_rec <= rec[s];
    @(posedge clk);
    fault_upd <= 1'b0;
    act_m[s] = a;
    if (!a) prev_m[s] = 1'b1;
  endtask
  task automatic ask(input logic [17:0] p);
    @(posedge clk);
    req_valid <= 1'b1;
    req_pgn <= p;
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  task automatic at(input int k);
    while (cyc % TK != k) @(posedge clk);
  endtask
  task automatic drain();
    repeat (600) if (mq.size() != 0 || tx_valid) @(posedge clk);
  endtask

  initial begin
    repeat (TK * 15) @(posedge clk);
    fail("watchdog expired");
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    bus(0, `DTCM_REG_CTRL, `DTCM_CTRL_RESET);
    bus(0, `DTCM_REG_INT_MASK, 32'h0000_0000);
    bus(0, `DTCM_REG_STATUS, 32'h0000_0000);
    bus(1, 8'h40, 32'hFFFF_FFFF);
    bus(0, 8'h40, 32'h0000_0000);
    bus(1, `DTCM_REG_INT_MASK, 32'h0000_000F);
    at(20);
    flt(2, 1);
    push(`DTCM_PGN_ACTIVE, 0, 0);
    at(80);
    flt(5, 1);
    push(`DTCM_PGN_ACTIVE, 0, 0);
    at(190);
    push(`DTCM_PGN_ACTIVE, 1, 0);
    slow <= 1'b1;
    at(20);
    flt(2, 0);
    at(190);
    push(`DTCM_PGN_ACTIVE, 1, 0);
    at(20);
    flt(5, 0);
    at(40);
    flt(1, 1);
    push(`DTCM_PGN_ACTIVE, 0, 0);
    at(80);
    flt(1, 0);
    at(100);
    flt(1, 1);
    at(120);
    flt(1, 0);
    at(190);
    push(`DTCM_PGN_ACTIVE, 1, 0);
    at(20);
    drain();
    lamp_on <= 4'h9;
    bus(0, `DTCM_REG_INT_STAT, 32'h0000_0001);
    ask(`DTCM_PGN_PREV);
    push(`DTCM_PGN_PREV, 0, 0);
    drain();
    cmp_irq(1'b1);
    bus(0, `DTCM_REG_INT_STAT, 32'h0000_0002);
    cmp_irq(1'b0);
    bus(1, `DTCM_REG_INT_MASK, 32'h0000_0000);
    ask(`DTCM_PGN_CLEAR);
    push(`DTCM_PGN_CLEAR, 0, 1);
    drain();
    cmp_irq(1'b0);
    volt_ok <= 1'b1;
    repeat (4) @(posedge clk);
    ask(`DTCM_PGN_CLEAR);
    prev_m = 8'h00;
    repeat (10) @(posedge clk);
    bus(0, `DTCM_REG_INT_STAT, 32'h0000_000C);
    ask(`DTCM_PGN_PREV);
    push(`DTCM_PGN_PREV, 0, 0);
    drain();
    ask(18'h0_FEDA);
    push(18'h0_FEDA, 0, 1);
    drain();
    ask(`DTCM_PGN_ACTIVE);
    push(`DTCM_PGN_ACTIVE, 0, 0);
    drain();
    // Disabled: no event or periodic report, requests still answered
    bus(1, `DTCM_REG_CTRL, 32'h0000_0000);
    flt(3, 1);
    bus(0, `DTCM_REG_STATUS, {16'h0000, prev_m, act_m});
    ask(`DTCM_PGN_ACTIVE);
    push(`DTCM_PGN_ACTIVE, 0, 0);
    drain();
    repeat (TK) @(posedge clk);
    chk(mq.size() == 0, "expected message missing");
    report_and_stop();
  end
endmodule

bind dtcm_messenger dtcm_checker u_chk (.clk, .nrst, .lamp_on, .req_valid, .req_pgn,
  .volt_ok, .tx_valid, .tx_ready, .tx_data, .tx_first, .tx_last, .tx_hdr);
